//--- design/ssc_defines.vh
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH

// frame layout
`define SSC_FRAME_BITS      5'd24
`define SSC_RW_BIT          23
`define SSC_ADDR_HI         22
`define SSC_ADDR_LO         16
`define SSC_DATA_HI         15
`define SSC_DATA_LO         0
`define SSC_HDR_BITS        5'd8

// register addresses
`define SSC_REG_CTRL        7'h00
`define SSC_REG_PRESCALE    7'h1E
`define SSC_REG_CHDIV       7'h23
`define SSC_REG_DIVIDER_MASTER_ENABLE    7'h24
`define SSC_REG_FRAC        7'h25
`define SSC_REG_OUT_A       7'h2E
`define SSC_REG_OUT_B       7'h2F
`define SSC_REG_SEED        7'h30

// control register fields
`define SSC_CTRL_SLEEP      0
`define SSC_CTRL_SOFT_RST   1
`define SSC_CTRL_PIN_SEL    2
`define SSC_CTRL_CAL        3
`define SSC_CTRL_LOCK_EN    13

// prescaler register fields
`define SSC_PRE_DIV4        0
`define SSC_PRE_DOUBLER     1

// channel divider fields
`define SSC_DIVIDER_SEGMENT_ONE      0
`define SSC_DIVIDER_SEGMENT_TWO_HI   3
`define SSC_DIVIDER_SEGMENT_TWO_LO   1
`define SSC_DIVIDER_SEGMENT_THREE_HI   6
`define SSC_DIVIDER_SEGMENT_THREE_LO   4
`define SSC_CHDIV_SEL_HI    8
`define SSC_CHDIV_SEL_LO    7

// channel divider enables
`define SSC_EN_MASTER       0
`define SSC_EN_SEG1         1
`define SSC_EN_SEG2         2
`define SSC_EN_SEG3         3
`define SSC_EN_DIST_A       4
`define SSC_EN_DIST         5

// fractional mode and output fields
`define SSC_FRAC_MODE       0
`define SSC_OUT_FROM_DIV    6
`define SSC_OUT_LEVEL_HI    5
`define SSC_OUT_LEVEL_LO    0

// reset values
`define SSC_RST_CTRL        16'h0000
`define SSC_RST_PRESCALE    16'h0000
`define SSC_RST_CHDIV       16'h0000
`define SSC_RST_DIVIDER_MASTER_ENABLE    16'h0000
`define SSC_RST_FRAC        16'h0000
`define SSC_RST_OUT         16'h0000

// segment selector codes
`define SSC_SEL_SEG1        2'd0
`define SSC_SEL_SEG12       2'd1
`define SSC_SEL_SEG123      2'd2

`endif

//--- design/ssc_sync2.v
// two-stage synchroniser for one asynchronous level
module ssc_sync2 (
   // clock and reset
   input  wire ref_clk,
   input  wire reset_n,
   // level
   input  wire async_in,
   output wire sync_out
);

   reg meta_q;
   reg sync_q;

   // meta_q feeds nothing but sync_q
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule // ssc_sync2

//--- design/ssc_regmem.v
// 128 x 16 register store, one write and one registered read port
module ssc_regmem (
   // clock and reset
   input  wire        ref_clk,
   input  wire        reset_n,
   // write port
   input  wire        wr_en,
   input  wire [6:0]  wr_addr,
   input  wire [15:0] wr_data,
   // read port
   input  wire        rd_en,
   input  wire [6:0]  rd_addr,
   output reg  [15:0] rd_data_q
);

   reg [15:0]  mem [0:127];
   reg [127:0] written_q;

   // array itself is not reset; unwritten words read as zero instead
   always @(posedge ref_clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
   end

   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         written_q <= 128'h0;
         rd_data_q <= 16'h0000;
      end
      else
      begin
         if (wr_en)
            written_q[wr_addr] <= 1'b1;
         if (rd_en)
            rd_data_q <= written_q[rd_addr] ? mem[rd_addr] : 16'h0000;
      end
   end

endmodule // ssc_regmem

//--- design/ssc_serial_ctrl.v
`include "ssc_defines.vh"

module ssc_serial_ctrl (
   // clock and reset
   input  wire        ref_clk,
   input  wire        reset_n,
   // serial link
   input  wire        serial_clk,
   input  wire        serial_select_n,
   input  wire        serial_data_in,
   output reg         multi_function_out,
   // device pins and analog status
   input  wire        chip_enable,
   input  wire        pll_locked,
   // power and calibration
   output wire        powered_down,
   output reg         calibrate_start,
   output reg         soft_reset,
   // feedback prescaler
   output wire        prescaler_div4,
   output wire        oscillator_doubler_enable,
   // channel divider
   output reg  [7:0]  channel_division,
   output wire        divider_master_enable,
   output wire        segment_one_active,
   output wire        segment_two_active,
   output wire        segment_three_active,
   output wire        dist_buffer_a_active,
   output wire        dist_buffer_active,
   // outputs
   output wire        output_a_from_divider,
   output wire        output_b_from_divider,
   output wire [5:0]  output_a_level,
   output wire [5:0]  output_b_level,
   // phase adjust
   output reg         phase_shift,
   output reg  [15:0] phase_shift_amount
);

   // segment code to divide value for segments two and three
   function [3:0] seg_value;
      input [2:0] code;
      begin
         case (code)
            3'd0:    seg_value = 4'd1;
            3'd1:    seg_value = 4'd2;
            3'd2:    seg_value = 4'd4;
            3'd3:    seg_value = 4'd6;
            3'd4:    seg_value = 4'd8;
            default: seg_value = 4'd1;
         endcase
      end
   endfunction

   localparam NSYNC = 5;

   wire [NSYNC-1:0] async_vec;
   wire [NSYNC-1:0] sync_vec;
   wire             sclk_s;
   wire             sel_n_s;
   wire             sdi_s;
   wire             ce_s;
   wire             lock_s;

   // select is carried inverted so the synchroniser's reset value reads
   // as an idle, deselected link and no false select edge follows reset
   assign async_vec = {pll_locked, chip_enable, serial_data_in,
                       ~serial_select_n, serial_clk};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1)
      begin : g_sync
         ssc_sync2 u_sync (
            .ref_clk  (ref_clk),
            .reset_n  (reset_n),
            .async_in (async_vec[gi]),
            .sync_out (sync_vec[gi])
         );
      end
   endgenerate

   assign sclk_s  = sync_vec[0];
   assign sel_n_s = ~sync_vec[1];
   assign sdi_s   = sync_vec[2];
   assign ce_s    = sync_vec[3];
   assign lock_s  = sync_vec[4];

   reg         sclk_prev_q;
   reg         sel_prev_q;
   reg  [23:0] shift_q;
   reg  [4:0]  bit_cnt_q;
   reg         rd_req_q;
   reg         rb_load_q;
   reg  [15:0] rb_shift_q;
   reg  [15:0] ctrl_q;
   reg  [15:0] pre_q;
   reg  [15:0] chdiv_q;
   reg  [15:0] chen_q;
   reg  [15:0] frac_q;
   reg  [15:0] outa_q;
   reg  [15:0] outb_q;

   wire        sclk_rise;
   wire        sclk_fall;
   wire        sel_rise;
   wire        sel_fall;
   wire        active;
   wire        hdr_done;
   wire [23:0] shift_d;
   wire        wr_commit;
   wire [6:0]  wr_addr;
   wire [15:0] wr_data;
   wire [6:0]  rd_addr;
   wire [15:0] rd_data;

   assign sclk_rise = sclk_s & ~sclk_prev_q;
   assign sclk_fall = ~sclk_s & sclk_prev_q;
   assign sel_rise  = sel_n_s & ~sel_prev_q;
   assign sel_fall  = ~sel_n_s & sel_prev_q;
   assign active    = ~sel_n_s;
   assign shift_d   = {shift_q[22:0], sdi_s};
   // header complete on the 8th rising edge with the read flag set
   assign hdr_done  = active & sclk_rise
                      & (bit_cnt_q == `SSC_HDR_BITS - 5'd1)
                      & shift_q[6];
   assign rd_addr   = shift_d[6:0];
   // short or long frames are dropped rather than half-applied
   assign wr_commit = sel_rise & (bit_cnt_q == `SSC_FRAME_BITS)
                      & ~shift_q[`SSC_RW_BIT];
   assign wr_addr   = shift_q[`SSC_ADDR_HI:`SSC_ADDR_LO];
   assign wr_data   = shift_q[`SSC_DATA_HI:`SSC_DATA_LO];

   ssc_regmem u_mem (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .wr_en     (wr_commit),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .rd_en     (hdr_done),
      .rd_addr   (rd_addr),
      .rd_data_q (rd_data)
   );

   // frame capture and readback shifter
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sclk_prev_q <= 1'b0;
         sel_prev_q  <= 1'b1;
         shift_q     <= 24'h00_0000;
         bit_cnt_q   <= 5'd0;
         rd_req_q    <= 1'b0;
         rb_load_q   <= 1'b0;
         rb_shift_q  <= 16'h0000;
      end
      else
      begin
         sclk_prev_q <= sclk_s;
         sel_prev_q  <= sel_n_s;
         rb_load_q   <= hdr_done;
         if (sel_fall)
         begin
            bit_cnt_q <= 5'd0;
            rd_req_q  <= 1'b0;
         end
         else if (active & sclk_rise)
         begin
            shift_q <= shift_d;
            if (bit_cnt_q != 5'd31)
               bit_cnt_q <= bit_cnt_q + 5'd1;
         end
         if (hdr_done)
            rd_req_q <= 1'b1;
         else if (sel_rise)
            rd_req_q <= 1'b0;
         // data bits of a read frame are never committed
         if (rb_load_q)
            rb_shift_q <= rd_data;
         // the fall after the header keeps bit 15 up for the ninth rise
         else if (rd_req_q & active & sclk_fall
                  & (bit_cnt_q > `SSC_HDR_BITS))
            rb_shift_q <= {rb_shift_q[14:0], 1'b0};
         else if (sel_rise)
            rb_shift_q <= 16'h0000;
      end
   end

   // shadow copies of the registers that steer hardware
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_q             <= `SSC_RST_CTRL;
         pre_q              <= `SSC_RST_PRESCALE;
         chdiv_q            <= `SSC_RST_CHDIV;
         chen_q             <= `SSC_RST_DIVIDER_MASTER_ENABLE;
         frac_q             <= `SSC_RST_FRAC;
         outa_q             <= `SSC_RST_OUT;
         outb_q             <= `SSC_RST_OUT;
         calibrate_start    <= 1'b0;
         soft_reset         <= 1'b0;
         phase_shift        <= 1'b0;
         phase_shift_amount <= 16'h0000;
      end
      else
      begin
         calibrate_start <= 1'b0;
         soft_reset      <= 1'b0;
         phase_shift     <= 1'b0;
         if (wr_commit)
         begin
            case (wr_addr)
               `SSC_REG_CTRL:
               begin
                  ctrl_q          <= wr_data;
                  calibrate_start <= wr_data[`SSC_CTRL_CAL];
                  soft_reset      <= wr_data[`SSC_CTRL_SOFT_RST];
               end
               `SSC_REG_PRESCALE: pre_q   <= wr_data;
               `SSC_REG_CHDIV:    chdiv_q <= wr_data;
               `SSC_REG_DIVIDER_MASTER_ENABLE: chen_q  <= wr_data;
               `SSC_REG_FRAC:     frac_q  <= wr_data;
               `SSC_REG_OUT_A:    outa_q  <= wr_data;
               `SSC_REG_OUT_B:    outb_q  <= wr_data;
               `SSC_REG_SEED:
               begin
                  // integer mode has no modulator to re-seed
                  if (frac_q[`SSC_FRAC_MODE])
                  begin
                     phase_shift        <= 1'b1;
                     phase_shift_amount <= wr_data;
                  end
               end
               default:
               begin
               end
            endcase
         end
      end
   end

   // multi-function pin
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         multi_function_out <= 1'b0;
      else if (ctrl_q[`SSC_CTRL_PIN_SEL] == 1'b0)
         multi_function_out <= rb_shift_q[15];
      else
         multi_function_out <= ctrl_q[`SSC_CTRL_LOCK_EN]
                               & lock_s;
   end

   // either cause holds the part down; recalibration is left to the host
   assign powered_down = ~ce_s | ctrl_q[`SSC_CTRL_SLEEP];

   assign oscillator_doubler_enable = pre_q[`SSC_PRE_DOUBLER];
   assign prescaler_div4 = pre_q[`SSC_PRE_DIV4]
                           | pre_q[`SSC_PRE_DOUBLER];

   // channel divider: a disabled segment two or three passes through as divide by one; segment one off gives zero
   wire [1:0] seg_sel;
   wire [3:0] seg1_val;
   wire [3:0] seg2_val;
   wire [3:0] seg3_val;
   wire [7:0] div12;
   wire [9:0] div123;

   assign divider_master_enable = chen_q[`SSC_EN_MASTER];
   assign seg_sel = chdiv_q[`SSC_CHDIV_SEL_HI:`SSC_CHDIV_SEL_LO];
   assign segment_one_active = divider_master_enable
                               & chen_q[`SSC_EN_SEG1];
   assign segment_two_active = divider_master_enable
                               & chen_q[`SSC_EN_SEG2]
                               & (seg_sel != `SSC_SEL_SEG1);
   assign segment_three_active = divider_master_enable
                                 & chen_q[`SSC_EN_SEG3]
                                 & (seg_sel == `SSC_SEL_SEG123);
   assign dist_buffer_a_active = divider_master_enable
                                 & chen_q[`SSC_EN_DIST_A];
   assign dist_buffer_active = divider_master_enable
                               & chen_q[`SSC_EN_DIST];

   assign seg1_val = chdiv_q[`SSC_DIVIDER_SEGMENT_ONE] ? 4'd3 : 4'd2;
   assign seg2_val = segment_two_active
      ? seg_value(chdiv_q[`SSC_DIVIDER_SEGMENT_TWO_HI:`SSC_DIVIDER_SEGMENT_TWO_LO])
      : 4'd1;
   assign seg3_val = segment_three_active
      ? seg_value(chdiv_q[`SSC_DIVIDER_SEGMENT_THREE_HI:`SSC_DIVIDER_SEGMENT_THREE_LO])
      : 4'd1;
   assign div12  = {4'h0, seg1_val} * {4'h0, seg2_val};
   assign div123 = {2'b00, div12} * {6'd0, seg3_val};

   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         channel_division <= 8'h00;
      else if (!segment_one_active)
         channel_division <= 8'h00;
      else
         channel_division <= div123[7:0];
   end

   assign output_a_from_divider = outa_q[`SSC_OUT_FROM_DIV];
   assign output_b_from_divider = outb_q[`SSC_OUT_FROM_DIV];
   assign output_a_level =
      outa_q[`SSC_OUT_LEVEL_HI:`SSC_OUT_LEVEL_LO];
   assign output_b_level =
      outb_q[`SSC_OUT_LEVEL_HI:`SSC_OUT_LEVEL_LO];

endmodule // ssc_serial_ctrl

//--- test/ssc_serial_ctrl_assertions.sv
module ssc_serial_ctrl_assertions (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       reset_n,
   // pins seen by the block
   input wire logic       serial_select_n,
   input wire logic       chip_enable,
   // observed outputs
   input wire logic       powered_down,
   input wire logic       calibrate_start,
   input wire logic       soft_reset,
   input wire logic       phase_shift,
   input wire logic       prescaler_div4,
   input wire logic       oscillator_doubler_enable,
   input wire logic [7:0] channel_division,
   input wire logic       divider_master_enable,
   input wire logic       segment_one_active,
   input wire logic       segment_two_active,
   input wire logic       segment_three_active,
   input wire logic [5:0] output_a_level,
   input wire logic [5:0] output_b_level,
   input wire logic       output_a_from_divider,
   input wire logic       output_b_from_divider
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   // three low samples cover the two-stage synchroniser
   a_ce_low_sleeps: assert property (
      !chip_enable [*3] |-> powered_down)
      else $error("chip enable low without power-down");
   a_doubler_div4: assert property (
      oscillator_doubler_enable |-> prescaler_div4)
      else $error("doubler on but prescaler not forced");
   a_master_gates_all: assert property (!divider_master_enable |->
      !(segment_one_active || segment_two_active || segment_three_active))
      else $error("segment active with divider disabled");
   a_cal_one_pulse: assert property (calibrate_start |->
      !$past(calibrate_start) && $past(serial_select_n, 3))
      else $error("calibration pulse outside a committed write");
   a_soft_rst_pulse: assert property (soft_reset |->
      $past(serial_select_n, 3) ##1 !soft_reset)
      else $error("soft reset pulse malformed");
   a_seed_one_pulse: assert property (
      phase_shift |=> !phase_shift [*3])
      else $error("phase shift pulse repeated");
   a_division_range: assert property ((channel_division == 8'h00) ||
      (channel_division >= 8'h02 && channel_division <= 8'hC0))
      else $error("channel division out of range");
   a_out_after_frame: assert property (
      $changed({output_a_level, output_b_level, output_a_from_divider,
      output_b_from_divider}) |-> $past(serial_select_n, 3))
      else $error("output setting changed inside a frame");
endmodule // ssc_serial_ctrl_assertions

bind ssc_serial_ctrl ssc_serial_ctrl_assertions u_checker (
   .ref_clk, .reset_n, .serial_select_n, .chip_enable, .powered_down,
   .calibrate_start, .soft_reset, .phase_shift, .prescaler_div4,
   .oscillator_doubler_enable, .channel_division, .divider_master_enable,
   .segment_one_active, .segment_two_active, .segment_three_active,
   .output_a_level, .output_b_level, .output_a_from_divider,
   .output_b_from_divider
);

//--- test/ssc_host_model.sv
module ssc_host_model (
   // serial link
   output logic      serial_clk,
   output logic      serial_select_n,
   output logic      serial_data_in,
   input  wire logic multi_function_out,
   // stretch the high phase of the link clock
   input  wire logic slow
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      serial_clk = 1'b0;
      serial_select_n = 1'b1;
      serial_data_in = 1'b0;
   end

   task automatic xfer(input logic rw, input logic [6:0] addr,
                       input logic [15:0] data, output logic [15:0] rd);
      logic [23:0] frame;
      frame = {rw, addr, data};
      rd = 16'h0000;
      serial_select_n = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         serial_data_in = frame[i];
         #62.5 serial_clk = 1'b1;
         if (i < 16)
            rd[i] = multi_function_out;
         #(slow ? 100.0 : 62.5) serial_clk = 1'b0;
      end
      #62.5 serial_select_n = 1'b1;
      // released line must not keep the last bit
      serial_data_in = ~serial_data_in;
      #100;
   endtask
endmodule // ssc_host_model

//--- test/ssc_serial_ctrl_tb.sv
`define CHK(n, e, g) \
   begin \
      total_checks++; \
      if ((g) !== (e)) \
      begin \
         fail_count++; \
         $display("MISMATCH %s exp %0h got %0h", n, e, g); \
      end \
   end

module ssc_serial_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic        ref_clk, reset_n, chip_enable, pll_locked, slow;
   wire         serial_clk, serial_select_n, serial_data_in;
   wire         multi_function_out, powered_down, calibrate_start;
   wire         soft_reset, prescaler_div4, oscillator_doubler_enable;
   wire [7:0]   channel_division;
   wire         divider_master_enable, segment_one_active;
   wire         segment_two_active, segment_three_active;
   wire         dist_buffer_a_active, dist_buffer_active;
   wire         output_a_from_divider, output_b_from_divider;
   wire [5:0]   output_a_level, output_b_level;
   wire         phase_shift;
   wire [15:0]  phase_shift_amount;
   logic [15:0] d, rd, amt;
   logic [6:0]  a;
   logic [5:0]  e, lvl;
   logic        pth;
   logic [6:0]  freq_regs [5] = '{7'h26, 7'h2D, 7'h2C, 7'h29, 7'h28};
   wire  [5:0]  en_seen = {dist_buffer_active, dist_buffer_a_active,
                           segment_three_active, segment_two_active,
                           segment_one_active, divider_master_enable};
   int          fail_count, total_checks, n_cal, n_rst, n_ph, cycles;

   ssc_serial_ctrl dut (.*);
   ssc_host_model host (.*);

   always #4 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
   begin
      cycles++;
      if (calibrate_start === 1'b1) n_cal++;
      if (soft_reset === 1'b1) n_rst++;
      if (phase_shift === 1'b1)
      begin
         n_ph++;
         amt = phase_shift_amount;
      end
      if (cycles == 60000)
      begin
         fail_count++;
         end_sim();
      end
   end

   function automatic logic [7:0] seg(input logic [2:0] c);
      case (c)
         3'd1: return 8'h02;
         3'd2: return 8'h04;
         3'd3: return 8'h06;
         3'd4: return 8'h08;
         default: return 8'h01;
      endcase
   endfunction

   function automatic logic [7:0] div_exp(input logic [15:0] w);
      logic [7:0] s1;
      s1 = w[0] ? 8'h03 : 8'h02;
      if (w[8:7] == 2'd0) return s1;
      if (w[8:7] == 2'd1) return s1 * seg(w[3:1]);
      return s1 * seg(w[3:1]) * seg(w[6:4]);
   endfunction

   task automatic wr(input logic [6:0] ad, input logic [15:0] v);
      logic [15:0] junk;
      host.xfer(1'b0, ad, v, junk);
      @(negedge ref_clk);
   endtask

   task automatic end_sim();
      if (fail_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      ref_clk = 1'b0;
      reset_n = 1'b0;
      chip_enable = 1'b1;
      pll_locked = 1'b0;
      slow = 1'b0;
      void'($urandom(87));
      repeat (3) @(negedge ref_clk);
      reset_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      wr(7'h00, 16'h0002); // soft reset first
      `CHK("soft_reset", 1, n_rst)
      for (int i = 0; i < 6; i++)
      begin
         slow = i[1];
         d = 16'($urandom);
         a = i[0] ? 7'h2F : 7'h2E;
         wr(a, d);
         host.xfer(1'b1, a, 16'($urandom), rd);
         `CHK("readback", d, rd)
         lvl = i[0] ? output_b_level : output_a_level;
         pth = i[0] ? output_b_from_divider : output_a_from_divider;
         `CHK("level", d[5:0], lvl)
         `CHK("path", d[6], pth)
      end
      host.xfer(1'b1, 7'h2F, ~d, rd);
      @(negedge ref_clk);
      `CHK("read_no_write", d[5:0], output_b_level)
      host.xfer(1'b1, 7'h55, 16'hFFFF, rd);
      `CHK("unwritten", 16'h0000, rd)
      for (int i = 0; i < 4; i++)
      begin
         wr(7'h1E, 16'(i));
         `CHK("div4", i[0] | i[1], prescaler_div4)
         `CHK("doubler", i[1], oscillator_doubler_enable)
      end
      wr(7'h24, 16'h003F);
      for (int i = 0; i < 14; i++)
      begin
         // corner case first: the largest division
         d = (i == 0) ? 16'h0149 : {7'h00, 2'($urandom_range(2)), 7'($urandom)};
         wr(7'h23, d);
         `CHK("division", div_exp(d), channel_division)
      end
      wr(7'h23, 16'h0149);
      for (int i = 0; i < 8; i++)
      begin
         e = (i == 0) ? 6'h3E : 6'($urandom);
         wr(7'h24, {10'h000, e});
         `CHK("enables", {6{e[0]}} & {e[5:1], 1'b1}, en_seen)
      end
      chip_enable = 1'b0;
      repeat (4) @(negedge ref_clk);
      `CHK("pd_pin", 1'b1, powered_down)
      chip_enable = 1'b1;
      repeat (4) @(negedge ref_clk);
      `CHK("pd_pin_off", 1'b0, powered_down)
      wr(7'h00, 16'h0001);
      `CHK("pd_bit", 1'b1, powered_down)
      wr(7'h00, 16'h0008); // recalibrate after wake
      `CHK("pd_bit_off", 1'b0, powered_down)
      `CHK("cal", 1, n_cal)
      wr(7'h00, 16'h2004);
      for (int i = 0; i < 3; i++)
      begin
         pll_locked = i[0];
         repeat (6) @(negedge ref_clk);
         `CHK("lock_pin", i[0], multi_function_out)
      end
      wr(7'h00, 16'h0004);
      pll_locked = 1'b1;
      repeat (6) @(negedge ref_clk);
      `CHK("lock_off", 1'b0, multi_function_out)
      // divider, numerator, denominator, then calibrate
      foreach (freq_regs[k])
         wr(freq_regs[k], 16'hFFFF);
      wr(7'h00, 16'h0008);
      `CHK("cal_freq", 2, n_cal)
      d = 16'($urandom_range(16'h7FFF)); // seed below denominator
      wr(7'h30, d);
      `CHK("seed_int", 0, n_ph)
      wr(7'h25, 16'h0001);
      for (int i = 1; i < 3; i++)
      begin
         d = 16'($urandom_range(16'h7FFF));
         wr(7'h30, d);
         `CHK("seed_count", i, n_ph)
         `CHK("seed_amount", d, amt)
      end
      end_sim();
   end
endmodule // ssc_serial_ctrl_tb
